// File: design/multifunction_gpio_los_slow_port.sv
`timescale 1ns/1ps
`include "gpio_los_defs.svh"

module multifunction_gpio_los_slow_port
   import gpio_los_pkg::*;
#(
   parameter int ADDR_W   = 16,
   parameter int HALF_CYC = `EXTRACT_HALF_CYC
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   // link clocks, taken from the shared clock pins
   input  wire logic              slow_egress_clock,
   input  wire logic              slow_ingress_clock,
   // register port
   input  wire logic [ADDR_W-1:0] cpu_addr,
   input  wire logic [7:0]        cpu_wdata,
   input  wire logic              cpu_wr,
   input  wire logic              cpu_rd,
   output logic      [7:0]        cpu_rdata,
   // configuration
   input  wire logic [1:0]        framer_enable,
   input  wire logic              slow_egress_port_enable,
   input  wire logic              slow_egress_insert,
   input  wire logic              slow_ingress_port_enable,
   input  wire logic              slow_ingress_insert,
   // shared pins of channels 0 and 1
   input  wire logic [1:0]        pin_in,
   output logic      [1:0]        pin_out,
   output logic      [1:0]        pin_oe,
   // egress rails
   input  wire logic              slow_egress_positive_rail_in,
   output logic                   slow_egress_positive_rail_out,
   output logic                   slow_egress_positive_rail_oe,
   input  wire logic              slow_egress_negative_rail_in,
   output logic                   slow_egress_negative_rail_out,
   output logic                   slow_egress_negative_rail_oe,
   // ingress rails
   input  wire logic              slow_ingress_positive_rail_in,
   output logic                   slow_ingress_positive_rail_out,
   output logic                   slow_ingress_positive_rail_oe,
   input  wire logic              slow_ingress_negative_rail_in,
   output logic                   slow_ingress_negative_rail_out,
   output logic                   slow_ingress_negative_rail_oe,
   // loss of signal towards the framer channels
   output logic      [1:0]        external_signal_loss,
   // egress stream
   output logic                   egress_insert_valid,
   output logic                   egress_insert_pos,
   output logic                   egress_insert_neg,
   input  wire logic              egress_extract_pos,
   input  wire logic              egress_extract_neg,
   output logic                   egress_extract_take,
   // ingress stream
   output logic                   ingress_insert_valid,
   output logic                   ingress_insert_pos,
   output logic                   ingress_insert_neg,
   input  wire logic              ingress_extract_pos,
   input  wire logic              ingress_extract_neg,
   output logic                   ingress_extract_take
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic [7:0]  pin_data_r;
   logic [7:0]  pin_dir_r;
   logic [1:0]  pin_s;
   logic [1:0]  slow_en;
   logic [1:0]  slow_ins;
   logic [1:0]  link_clk;
   logic [1:0]  rail_pos_in;
   logic [1:0]  rail_neg_in;
   logic [1:0]  ext_pos;
   logic [1:0]  ext_neg;
   logic [1:0]  ins_valid;
   logic [1:0]  ins_pos;
   logic [1:0]  ins_neg;
   logic [1:0]  ext_take;
   logic [1:0]  lane_clk;
   logic [1:0]  lane_pos;
   logic [1:0]  lane_neg;
   logic [1:0]  rail_pos_out_r;
   logic [1:0]  rail_neg_out_r;
   logic [1:0]  rail_oe_r;
   logic [7:0]  pin_data_view;
   role_t       role [2];

   // -----------------------------------------------------------------
   // lane mapping: lane 0 egress on pin 0, lane 1 ingress on pin 1
   // -----------------------------------------------------------------
   assign slow_en     = {slow_ingress_port_enable, slow_egress_port_enable};
   assign slow_ins    = {slow_ingress_insert, slow_egress_insert};
   assign link_clk    = {slow_ingress_clock, slow_egress_clock};
   assign rail_pos_in = {slow_ingress_positive_rail_in, slow_egress_positive_rail_in};
   assign rail_neg_in = {slow_ingress_negative_rail_in, slow_egress_negative_rail_in};
   assign ext_pos     = {ingress_extract_pos, egress_extract_pos};
   assign ext_neg     = {ingress_extract_neg, egress_extract_neg};

   assign egress_insert_valid  = ins_valid[`LANE_EGRESS];
   assign egress_insert_pos    = ins_pos[`LANE_EGRESS];
   assign egress_insert_neg    = ins_neg[`LANE_EGRESS];
   assign egress_extract_take  = ext_take[`LANE_EGRESS];
   assign ingress_insert_valid = ins_valid[`LANE_INGRESS];
   assign ingress_insert_pos   = ins_pos[`LANE_INGRESS];
   assign ingress_insert_neg   = ins_neg[`LANE_INGRESS];
   assign ingress_extract_take = ext_take[`LANE_INGRESS];

   assign slow_egress_positive_rail_out  = rail_pos_out_r[`LANE_EGRESS];
   assign slow_egress_negative_rail_out  = rail_neg_out_r[`LANE_EGRESS];
   assign slow_egress_positive_rail_oe   = rail_oe_r[`LANE_EGRESS];
   assign slow_egress_negative_rail_oe   = rail_oe_r[`LANE_EGRESS];
   assign slow_ingress_positive_rail_out = rail_pos_out_r[`LANE_INGRESS];
   assign slow_ingress_negative_rail_out = rail_neg_out_r[`LANE_INGRESS];
   assign slow_ingress_positive_rail_oe  = rail_oe_r[`LANE_INGRESS];
   assign slow_ingress_negative_rail_oe  = rail_oe_r[`LANE_INGRESS];

   // -----------------------------------------------------------------
   // pin input synchroniser
   // -----------------------------------------------------------------
   pin_sync #(.WIDTH(2)) u_pin_sync (
      .clk      (clk_sys),
      .async_in (pin_in),
      .sync_out (pin_s)
   );

   // -----------------------------------------------------------------
   // register writes
   // -----------------------------------------------------------------
   // output data store
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pin_data_r <= `PIN_DATA_RST;
      end else if (cpu_wr) begin
         if (cpu_addr == ADDR_W'(`PIN_DATA_OFS)) begin
            pin_data_r <= cpu_wdata;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pin_dir_r <= `PIN_DIR_RST;
      end else if (cpu_wr) begin
         if (cpu_addr == ADDR_W'(`PIN_DIR_OFS)) begin
            pin_dir_r <= cpu_wdata;
         end
      end
   end

   // -----------------------------------------------------------------
   // register reads
   // -----------------------------------------------------------------
   // input pins read level
   always_comb begin
      pin_data_view = pin_data_r;
      pin_data_view[`PIN_BIT_CH0] = pin_dir_r[`PIN_BIT_CH0] ?
                                    pin_data_r[`PIN_BIT_CH0] : pin_s[`PIN_BIT_CH0];
      pin_data_view[`PIN_BIT_CH1] = pin_dir_r[`PIN_BIT_CH1] ?
                                    pin_data_r[`PIN_BIT_CH1] : pin_s[`PIN_BIT_CH1];
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cpu_rdata <= `RDATA_RST;
      end else if (cpu_rd) begin
         if (cpu_addr == ADDR_W'(`PIN_DATA_OFS)) begin
            cpu_rdata <= pin_data_view;
         end else if (cpu_addr == ADDR_W'(`PIN_DIR_OFS)) begin
            cpu_rdata <= pin_dir_r;
         end else begin
            cpu_rdata <= `RDATA_RST;
         end
      end
   end

   // -----------------------------------------------------------------
   // per pin: role, drive and loss flag
   // -----------------------------------------------------------------
   for (genvar n = 0; n < 2; n++) begin : g_pin

      always_comb begin
         if (slow_en[n]) begin
            role[n] = ROLE_SLOW;
         end else if (framer_enable[n]) begin
            role[n] = ROLE_LOS;
         end else begin
            role[n] = ROLE_GPIO;
         end
      end

      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            pin_out[n] <= 1'b0;
         end else begin
            case (role[n])
               ROLE_SLOW: begin
                  pin_out[n] <= lane_clk[n];
               end
               ROLE_LOS: begin
                  pin_out[n] <= 1'b0;
               end
               ROLE_GPIO: begin
                  pin_out[n] <= pin_data_r[n];
               end
               default: begin
                  pin_out[n] <= 1'b0;
               end
            endcase
         end
      end

      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            pin_oe[n] <= 1'b0;
         end else begin
            case (role[n])
               ROLE_SLOW: begin
                  pin_oe[n] <= ~slow_ins[n];
               end
               ROLE_LOS: begin
                  pin_oe[n] <= 1'b0;
               end
               ROLE_GPIO: begin
                  pin_oe[n] <= pin_dir_r[n];
               end
               default: begin
                  pin_oe[n] <= 1'b0;
               end
            endcase
         end
      end

      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            external_signal_loss[n] <= 1'b0;
         end else begin
            external_signal_loss[n] <= (role[n] == ROLE_LOS) & pin_s[n];
         end
      end

      // -----------------------------------------------------------------
      // slow-port rails
      // -----------------------------------------------------------------
      // rails follow the lane
      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            rail_pos_out_r[n] <= 1'b0;
            rail_neg_out_r[n] <= 1'b0;
         end else begin
            rail_pos_out_r[n] <= lane_pos[n];
            rail_neg_out_r[n] <= lane_neg[n];
         end
      end

      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            rail_oe_r[n] <= 1'b0;
         end else begin
            rail_oe_r[n] <= slow_en[n] & ~slow_ins[n];
         end
      end

      slow_port_lane #(.HALF_CYC(HALF_CYC)) u_lane (
         .clk_sys     (clk_sys),
         .sys_rst     (sys_rst),
         .enable      (slow_en[n]),
         .insert      (slow_ins[n]),
         .link_clk    (link_clk[n]),
         .rail_pos_in (rail_pos_in[n]),
         .rail_neg_in (rail_neg_in[n]),
         .ins_valid   (ins_valid[n]),
         .ins_pos     (ins_pos[n]),
         .ins_neg     (ins_neg[n]),
         .ext_pos     (ext_pos[n]),
         .ext_neg     (ext_neg[n]),
         .ext_take    (ext_take[n]),
         .clk_out     (lane_clk[n]),
         .pos_out     (lane_pos[n]),
         .neg_out     (lane_neg[n])
      );
   end

endmodule // multifunction_gpio_los_slow_port

// File: common/gpio_los_defs.svh
`ifndef GPIO_LOS_DEFS_SVH
`define GPIO_LOS_DEFS_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define PIN_DATA_OFS      16'h0147
`define PIN_DIR_OFS       16'h014b

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define PIN_BIT_CH0       0
`define PIN_BIT_CH1       1
`define LANE_EGRESS       0
`define LANE_INGRESS      1

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define PIN_DATA_RST      8'h00
`define PIN_DIR_RST       8'h00
`define RDATA_RST         8'h00

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define SYS_CLK_NS        50
`define EXTRACT_HALF_NS   100
`define EXTRACT_HALF_CYC  (((`EXTRACT_HALF_NS) + (`SYS_CLK_NS) - 1) / (`SYS_CLK_NS))

`endif

// File: common/gpio_los_pkg.sv
package gpio_los_pkg;

   // role of one shared pin
   typedef enum logic [2:0] {
      ROLE_GPIO = 3'b001,
      ROLE_LOS  = 3'b010,
      ROLE_SLOW = 3'b100
   } role_t;

endpackage

// File: design/pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
   parameter int WIDTH = 1
) (
   // clock
   input  wire logic             clk,
   // asynchronous level in, synchronised level out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk) begin
      meta_r   <= async_in;
      sync_out <= meta_r;
   end

endmodule // pin_sync

// File: design/slow_port_lane.sv
`timescale 1ns/1ps
`include "gpio_los_defs.svh"

module slow_port_lane #(
   parameter int HALF_CYC = `EXTRACT_HALF_CYC
) (
   // system clock domain
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic enable,
   input  wire logic insert,
   // link clock and raw rail pins
   input  wire logic link_clk,
   input  wire logic rail_pos_in,
   input  wire logic rail_neg_in,
   // inserted stream towards the device
   output logic      ins_valid,
   output logic      ins_pos,
   output logic      ins_neg,
   // extracted stream from the device
   input  wire logic ext_pos,
   input  wire logic ext_neg,
   output logic      ext_take,
   // generated clock and rails
   output logic      clk_out,
   output logic      pos_out,
   output logic      neg_out
);

   logic [15:0] div_cnt_r;
   logic        lrst_meta_r;
   logic        lrst_r;
   logic        cap_pos_r;
   logic        cap_neg_r;
   logic        cap_tog_r;
   logic        tog_s;
   logic        tog_d_r;
   logic        extract_on;

   assign extract_on = enable & ~insert;

   // -----------------------------------------------------------------
   // link domain: capture on falling edge
   // -----------------------------------------------------------------
   always_ff @(negedge link_clk) begin
      lrst_meta_r <= sys_rst;
      lrst_r      <= lrst_meta_r;
   end

   always_ff @(negedge link_clk) begin
      if (lrst_r) begin
         cap_pos_r <= 1'b0;
         cap_neg_r <= 1'b0;
         cap_tog_r <= 1'b0;
      end else begin
         cap_pos_r <= rail_pos_in;
         cap_neg_r <= rail_neg_in;
         cap_tog_r <= ~cap_tog_r;
      end
   end

   // -----------------------------------------------------------------
   // system domain: pick up each captured pair
   // -----------------------------------------------------------------
   pin_sync #(.WIDTH(1)) u_tog_sync (
      .clk      (clk_sys),
      .async_in (cap_tog_r),
      .sync_out (tog_s)
   );

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tog_d_r   <= 1'b0;
         ins_valid <= 1'b0;
         ins_pos   <= 1'b0;
         ins_neg   <= 1'b0;
      end else begin
         tog_d_r   <= tog_s;
         ins_valid <= enable & insert & (tog_s ^ tog_d_r);
         if (tog_s ^ tog_d_r) begin
            ins_pos <= cap_pos_r;
            ins_neg <= cap_neg_r;
         end
      end
   end

   // -----------------------------------------------------------------
   // extract: divided clock, rails change with its rising edge
   // -----------------------------------------------------------------
   // rising edge update
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !extract_on) begin
         div_cnt_r <= 16'h0000;
         clk_out   <= 1'b0;
         pos_out   <= 1'b0;
         neg_out   <= 1'b0;
         ext_take  <= 1'b0;
      end else if (div_cnt_r == 16'(HALF_CYC - 1)) begin
         div_cnt_r <= 16'h0000;
         clk_out   <= ~clk_out;
         ext_take  <= ~clk_out;
         if (!clk_out) begin
            pos_out <= ext_pos;
            neg_out <= ext_neg;
         end
      end else begin
         div_cnt_r <= div_cnt_r + 16'h0001;
         ext_take  <= 1'b0;
      end
   end

endmodule // slow_port_lane

// File: verification/gpio_los_monitor.sv
`timescale 1ns/1ps
module gpio_los_monitor
   import gpio_los_pkg::*;
#(
   parameter int HALF_CYC = 2
) (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   // configuration
   input wire logic [1:0] framer_enable,
   input wire logic       slow_egress_port_enable,
   input wire logic       slow_egress_insert,
   input wire logic       slow_ingress_port_enable,
   input wire logic       slow_ingress_insert,
   // pins
   input wire logic [1:0] pin_in,
   input wire logic [1:0] pin_out,
   input wire logic [1:0] pin_oe,
   input wire logic       slow_egress_positive_rail_out,
   input wire logic       slow_ingress_positive_rail_out,
   // streams
   input wire logic [1:0] external_signal_loss,
   input wire logic       egress_insert_valid,
   input wire logic       egress_extract_pos,
   input wire logic       egress_extract_take,
   input wire logic       ingress_extract_pos,
   input wire logic       ingress_extract_take
);
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   los_detect_a: assert property (
      (framer_enable[1] && !slow_ingress_port_enable && pin_in[1])[*4] |-> external_signal_loss[1])
      else $error("pin 1 loss not declared");
   los_off_a: assert property (
      (!framer_enable[0] || slow_egress_port_enable)[*3] |-> !external_signal_loss[0])
      else $error("pin 0 loss outside loss role");
   los_ch1_off_a: assert property (
      (!framer_enable[1] || slow_ingress_port_enable)[*3] |-> !external_signal_loss[1])
      else $error("pin 1 loss outside loss role");
   los_no_drive_a: assert property (
      (framer_enable[0] && !slow_egress_port_enable)[*3] |-> !pin_oe[0])
      else $error("loss pin driven");
   egr_ins_quiet_a: assert property (
      (slow_egress_port_enable && slow_egress_insert)[*3] |-> !pin_oe[0])
      else $error("egress insert clock driven");
   ing_ins_quiet_a: assert property (
      (slow_ingress_port_enable && slow_ingress_insert)[*3] |-> !pin_oe[1])
      else $error("ingress insert clock driven");
   egr_take_a: assert property (
      egress_extract_take |=> $rose(pin_out[0])
         && slow_egress_positive_rail_out == $past(egress_extract_pos, 2))
      else $error("egress rail not on clock rise");
   ing_take_a: assert property (
      ingress_extract_take |=> $rose(pin_out[1])
         && slow_ingress_positive_rail_out == $past(ingress_extract_pos, 2))
      else $error("ingress rail not on clock rise");
   ins_pulse_a: assert property (
      egress_insert_valid |-> slow_egress_port_enable && slow_egress_insert
         ##1 !egress_insert_valid)
      else $error("egress insert pulse wrong");
endmodule // gpio_los_monitor

bind multifunction_gpio_los_slow_port gpio_los_monitor #(.HALF_CYC(HALF_CYC)) u_mon (
   .clk_sys, .sys_rst, .framer_enable, .slow_egress_port_enable, .slow_egress_insert,
   .slow_ingress_port_enable, .slow_ingress_insert, .pin_in, .pin_out, .pin_oe,
   .slow_egress_positive_rail_out, .slow_ingress_positive_rail_out, .external_signal_loss,
   .egress_insert_valid, .egress_extract_pos, .egress_extract_take, .ingress_extract_pos,
   .ingress_extract_take
);

// File: verification/slow_link_model.sv
`timescale 1ns/1ps
module slow_link_model (
   // frame request
   input  wire logic        go,
   input  wire logic [7:0]  pos_bits,
   input  wire logic [7:0]  neg_bits,
   // insert side
   output logic             link_clk,
   output logic             pos,
   output logic             neg,
   // extract side
   input  wire logic        ext_clk,
   input  wire logic        ext_pos,
   input  wire logic        ext_neg,
   output logic      [15:0] cap
);
   initial begin
      cap = 16'h0000;
      pos = 1'b0;
      neg = 1'b0;
      link_clk = 1'b0;
      // clock runs past reset release so the link side leaves reset
      repeat (4) begin
         #80 link_clk = 1'b1;
         #80 link_clk = 1'b0;
      end
   end
   always @(posedge go) begin
      for (int i = 7; i >= 0; i--) begin
         link_clk = 1'b1;
         pos = pos_bits[i];
         neg = neg_bits[i];
         #80 link_clk = 1'b0;
         #80;
      end
      pos = ~pos;
      neg = ~neg;
   end
   always @(negedge ext_clk) cap = {cap[13:0], ext_pos, ext_neg};
endmodule // slow_link_model

// File: verification/test_multifunction_gpio_los_slow_port.sv
`timescale 1ns/1ps
`include "gpio_los_defs.svh"
module test_multifunction_gpio_los_slow_port;
   import gpio_los_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam logic [7:0] pat_p = 8'hb4;
   localparam logic [7:0] pat_n = 8'h4b;
   logic             clk_sys = 1'b0;
   logic             sys_rst = 1'b1;
   logic      [15:0] cpu_addr = 16'h0000;
   logic      [7:0]  cpu_wdata = 8'h00;
   logic             cpu_wr = 1'b0;
   logic             cpu_rd = 1'b0;
   logic      [1:0]  framer_enable = 2'h0;
   logic      [1:0]  en = 2'h0;
   logic      [1:0]  ins = 2'h0;
   logic      [1:0]  lvl = 2'h0;
   logic      [1:0]  go = 2'h0;
   logic      [1:0]  q [2][$];
   int               idx [2] = '{0, 0};
   int               fails = 0;
   int               comparisons = 0;
   int               cyc = 0;
   wire logic [7:0]  cpu_rdata;
   wire logic [1:0]  pin_out, pin_oe, pin_w, loss, ivalid, ipos, ineg, take, lclk, mpos, mneg;
   wire logic [1:0]  rp_out, rp_oe, rn_out, rn_oe, rp_w, rn_w, xp, xn;
   wire logic [15:0] cap [2];
   always #25 clk_sys = ~clk_sys;
   for (genvar l = 0; l < 2; l++) begin : g_lane
      assign pin_w[l] = pin_oe[l] ? pin_out[l] : (en[l] ? lclk[l] : lvl[l]);
      assign rp_w[l] = rp_oe[l] ? rp_out[l] : mpos[l];
      assign rn_w[l] = rn_oe[l] ? rn_out[l] : mneg[l];
      assign xp[l] = pat_p[idx[l][2:0]];
      assign xn[l] = pat_n[idx[l][2:0]];
      slow_link_model u_link (.go(go[l]), .pos_bits(pat_p), .neg_bits(pat_n),
         .link_clk(lclk[l]), .pos(mpos[l]), .neg(mneg[l]), .ext_clk(pin_w[l]),
         .ext_pos(rp_w[l]), .ext_neg(rn_w[l]), .cap(cap[l]));
   end
   multifunction_gpio_los_slow_port #(.HALF_CYC(2)) u_dut (
      .clk_sys, .sys_rst, .slow_egress_clock(lclk[0]), .slow_ingress_clock(lclk[1]),
      .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_rdata, .framer_enable,
      .slow_egress_port_enable(en[0]), .slow_egress_insert(ins[0]),
      .slow_ingress_port_enable(en[1]), .slow_ingress_insert(ins[1]),
      .pin_in(pin_w), .pin_out, .pin_oe, .external_signal_loss(loss),
      .slow_egress_positive_rail_in(rp_w[0]), .slow_egress_positive_rail_out(rp_out[0]),
      .slow_egress_positive_rail_oe(rp_oe[0]), .slow_egress_negative_rail_in(rn_w[0]),
      .slow_egress_negative_rail_out(rn_out[0]), .slow_egress_negative_rail_oe(rn_oe[0]),
      .slow_ingress_positive_rail_in(rp_w[1]), .slow_ingress_positive_rail_out(rp_out[1]),
      .slow_ingress_positive_rail_oe(rp_oe[1]), .slow_ingress_negative_rail_in(rn_w[1]),
      .slow_ingress_negative_rail_out(rn_out[1]), .slow_ingress_negative_rail_oe(rn_oe[1]),
      .egress_insert_valid(ivalid[0]), .egress_insert_pos(ipos[0]),
      .egress_insert_neg(ineg[0]), .egress_extract_pos(xp[0]), .egress_extract_neg(xn[0]),
      .egress_extract_take(take[0]), .ingress_insert_valid(ivalid[1]),
      .ingress_insert_pos(ipos[1]), .ingress_insert_neg(ineg[1]),
      .ingress_extract_pos(xp[1]), .ingress_extract_neg(xn[1]), .ingress_extract_take(take[1])
   );
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         results();
      end
      for (int l = 0; l < 2; l++) begin
         if (ivalid[l] === 1'b1) q[l].push_back({ipos[l], ineg[l]});
         if (take[l] === 1'b1) idx[l] <= idx[l] + 1;
      end
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic results();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      cpu_addr = a;
      cpu_wdata = d;
      cpu_wr = 1'b1;
      @(negedge clk_sys);
      cpu_wr = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      cpu_addr = a;
      cpu_rd = 1'b1;
      @(negedge clk_sys);
      cpu_rd = 1'b0;
      check(16'(cpu_rdata), 16'(exp));
   endtask
   task automatic t_gpio();
      rd(`PIN_DATA_OFS, 8'h00);
      rd(16'h0000, 8'h00);
      check(pin_oe, 2'b00);
      lvl = 2'b10;
      wr(`PIN_DIR_OFS, 8'h01);
      wr(`PIN_DATA_OFS, 8'ha5);
      step(3);
      check(pin_oe, 2'b01);
      check(pin_out[0], 1'b1);
      rd(`PIN_DATA_OFS, 8'ha7);
      lvl = 2'b01;
      wr(`PIN_DIR_OFS, 8'h02);
      wr(`PIN_DATA_OFS, 8'h5a);
      step(3);
      check(pin_oe, 2'b10);
      check(pin_out[1], 1'b1);
      rd(`PIN_DATA_OFS, 8'h5b);
      wr(16'h0000, 8'hff);
      rd(`PIN_DIR_OFS, 8'h02);
      wr(`PIN_DIR_OFS, 8'h00);
      $display("test gpio done");
   endtask
   task automatic t_los();
      framer_enable = 2'b11;
      lvl = 2'b11;
      step(5);
      check(loss, 2'b11);
      check(pin_oe, 2'b00);
      en[1] = 1'b1;
      ins[1] = 1'b1;
      step(5);
      check(loss, 2'b01);
      en[0] = 1'b1;
      ins[0] = 1'b1;
      step(5);
      check(loss, 2'b00);
      en = 2'b00;
      lvl = 2'b00;
      step(5);
      check(loss, 2'b00);
      framer_enable = 2'b00;
      $display("test loss done");
   endtask
   task automatic t_insert(input int l);
      en[l] = 1'b1;
      ins[l] = 1'b1;
      step(4);
      q[l].delete();
      go[l] = 1'b1;
      step(1);
      go[l] = 1'b0;
      step(34);
      check(16'(q[l].size()), 16'd8);
      for (int j = 0; j < 8; j++) check(q[l][j], {pat_p[7-j], pat_n[7-j]});
      check({rp_oe[l], rn_oe[l]}, 2'b00);
      en[l] = 1'b0;
      $display("test insert done");
   endtask
   task automatic t_extract(input int l);
      logic [15:0] e;
      e = 16'h0000;
      idx[l] = 0;
      ins[l] = 1'b0;
      en[l] = 1'b1;
      for (int k = 0; k < 80 && idx[l] < 8; k++) @(negedge clk_sys);
      step(2);
      for (int i = 0; i < 8; i++) e = {e[13:0], pat_p[i], pat_n[i]};
      check(cap[l], e);
      check(rp_oe[l], 1'b1);
      check(rn_oe[l], 1'b1);
      en[l] = 1'b0;
      step(4);
      $display("test extract done");
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      sys_rst = 1'b0;
      t_gpio();
      t_los();
      t_insert(0);
      t_insert(1);
      t_extract(0);
      t_extract(1);
      results();
   end
endmodule // test_multifunction_gpio_los_slow_port
